/* File: rtl/ecp_pkg.sv */
// ecp_pkg: constants, register map and carrier types of the event counter / capture block
// assumes a 32-bit APB master and a 100 MHz peripheral clock
package ecp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CCCTRL = 8'h04;
  localparam logic [7:0] OFF_PRESEL = 8'h08;
  localparam logic [7:0] OFF_CMPA   = 8'h0c;
  localparam logic [7:0] OFF_CAPB   = 8'h10;
  localparam logic [7:0] OFF_COUNT  = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // prescale_edge_select field positions, capture-enable and overflow bit positions
  localparam int CLK_SEL_LO    = 0;
  localparam int EDGE_SEL_A_LO = 4;
  localparam int EDGE_SEL_B_LO = 6;
  localparam int CAP_EN_BIT    = 0;
  localparam int OVF_BIT       = 0;
  // reset values
  localparam logic [15:0] CMP_RST    = 16'h0000;
  localparam logic [7:0]  PRESEL_RST = 8'h00;
  // edge select codes
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  // count clock codes and divider ends
  localparam logic [1:0] CLK_DIV1  = 2'b00;
  localparam logic [1:0] CLK_DIV4  = 2'b01;
  localparam logic [1:0] CLK_DIV256 = 2'b10;
  localparam logic [1:0] CLK_EDGE  = 2'b11;
  localparam logic [7:0] DIV4_END   = 8'h03;
  localparam logic [7:0] DIV256_END = 8'hff;
  localparam logic [15:0] CNT_MAX   = 16'hffff;

  typedef enum logic [1:0] {
    ECP_STOP,
    ECP_EVENT,
    ECP_FREE,
    ECP_RESTART
  } ecp_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ecp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ecp_apb_rsp_t;
endpackage : ecp_pkg

/* File: rtl/ecp_timer.sv */
// ecp_timer: 16-bit event counter with clear-on-match and two-input pulse capture
// assumes inputs synchronous to clk, a 32-bit APB master, synchronous active-high reset
//
// Contract
// - event mode: counter advances once per filtered valid edge of event_input_a
// - counter equal to compare_capture_a clears to zero, keeps counting, raises match_irq_a
// - edge of event_input_a chosen by bits 5:4 of prescale_edge_select
// - event mode samples event_input_a each clk; new level accepted after two samples
// - clear-on-match sets overflow flag only when compare holds ffff
// - capture inputs sampled at the count clock, or at clk when the count clock is the event_input_a edge, filtered by two equal samples
// - free running: edge on event_input_a copies counter to capture_b, capture_irq_b
// - free running: edge on capture_input_b copies counter to compare_capture_a, match_irq_a
// - free-running wrap sets the overflow flag
// - measurement free running or restarted on event_input_a edges
// - edge code 00 falling, 01 rising, 11 both, 10 none
// - count clock is clk, clk/4, clk/256 or event_input_a valid edge
//
// Implementation choices: the address map and register access over APB.
module ecp_timer (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register bus
  input  wire ecp_pkg::ecp_apb_req_t apb_req,
  output      ecp_pkg::ecp_apb_rsp_t apb_rsp,
  // external pins
  input  wire logic                 event_input_a,
  input  wire logic                 capture_input_b,
  // interrupt pulses
  output      logic                 match_irq_a,
  output      logic                 capture_irq_b
);

  typedef struct packed {
    ecp_pkg::ecp_mode_t mode;
    logic               cap_en;
    logic [7:0]         presel;
    logic [15:0]        cmp;
    logic [15:0]        capb;
    logic [15:0]        cnt;
    logic               ovf;
    logic [7:0]         pre;
    logic               fa_smp;
    logic               fa_lvl;
    logic               sa_smp;
    logic               sa_lvl;
    logic               sb_smp;
    logic               sb_lvl;
    logic               irq_a;
    logic               irq_b;
    ecp_pkg::ecp_apb_rsp_t rsp;
  } ecp_state_t;

  ecp_state_t s_q;
  ecp_state_t s_d;

  logic [1:0] clk_sel;
  logic [1:0] edge_a;
  logic [1:0] edge_b;
  logic       fa_edge;
  logic       sa_edge;
  logic       sb_edge;
  logic       pre_tick;
  logic       smp_tick;
  logic       cnt_tick;
  logic       run;
  logic       wr_en;
  logic       rd_en;

  // 10 never matches either branch
  function automatic logic edge_ok(input logic [1:0] sel, input logic lvl);
    edge_ok = (lvl && (sel == ecp_pkg::EDGE_RISE || sel == ecp_pkg::EDGE_BOTH)) ||
              (!lvl && (sel == ecp_pkg::EDGE_FALL || sel == ecp_pkg::EDGE_BOTH));
  endfunction : edge_ok

  assign clk_sel = s_q.presel[ecp_pkg::CLK_SEL_LO +: 2];
  assign edge_a  = s_q.presel[ecp_pkg::EDGE_SEL_A_LO +: 2];
  assign edge_b  = s_q.presel[ecp_pkg::EDGE_SEL_B_LO +: 2];

  // a level is accepted only once two consecutive samples agree
  assign fa_edge = (event_input_a == s_q.fa_smp) && (event_input_a != s_q.fa_lvl)
                   && edge_ok(edge_a, event_input_a);
  assign sa_edge = smp_tick && (event_input_a == s_q.sa_smp) && (event_input_a != s_q.sa_lvl)
                   && edge_ok(edge_a, event_input_a);
  assign sb_edge = smp_tick && (capture_input_b == s_q.sb_smp)
                   && (capture_input_b != s_q.sb_lvl)
                   && edge_ok(edge_b, capture_input_b);

  always_comb begin
    case (clk_sel)
      ecp_pkg::CLK_DIV1:   pre_tick = 1'b1;
      ecp_pkg::CLK_DIV4:   pre_tick = (s_q.pre[1:0] == ecp_pkg::DIV4_END[1:0]);
      ecp_pkg::CLK_DIV256: pre_tick = (s_q.pre == ecp_pkg::DIV256_END);
      default:             pre_tick = fa_edge;
    endcase
  end

  // with the pin edge as count clock, captures still sample at clk
  assign smp_tick = (clk_sel == ecp_pkg::CLK_EDGE) ? 1'b1 : pre_tick;
  assign cnt_tick = (s_q.mode == ecp_pkg::ECP_EVENT) ? fa_edge : pre_tick;
  assign run      = (s_q.mode != ecp_pkg::ECP_STOP);
  // writes land on the edge where the master sees pready
  assign wr_en    = apb_req.psel && apb_req.penable && apb_req.pwrite && s_q.rsp.pready;
  assign rd_en    = apb_req.psel && apb_req.penable && !s_q.rsp.pready;

  always_comb begin
    s_d = s_q;
    s_d.irq_a = 1'b0;
    s_d.irq_b = 1'b0;
    s_d.pre = s_q.pre + 8'h01;
    // filters run even while stopped, so the pin level is known at start
    s_d.fa_smp = event_input_a;
    if (event_input_a == s_q.fa_smp) begin
      s_d.fa_lvl = event_input_a;
    end
    if (smp_tick) begin
      s_d.sa_smp = event_input_a;
      s_d.sb_smp = capture_input_b;
      if (event_input_a == s_q.sa_smp) begin
        s_d.sa_lvl = event_input_a;
      end
      if (capture_input_b == s_q.sb_smp) begin
        s_d.sb_lvl = capture_input_b;
      end
    end

    // software side
    s_d.rsp.pready = rd_en;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata = 32'h0000_0000;
    if (rd_en) begin
      case (apb_req.paddr)
        ecp_pkg::OFF_MODE:   s_d.rsp.prdata = {30'h0000_0000, s_q.mode};
        ecp_pkg::OFF_CCCTRL: s_d.rsp.prdata = {31'h0000_0000, s_q.cap_en};
        ecp_pkg::OFF_PRESEL: s_d.rsp.prdata = {24'h00_0000, s_q.presel};
        ecp_pkg::OFF_CMPA:   s_d.rsp.prdata = {16'h0000, s_q.cmp};
        ecp_pkg::OFF_CAPB:   s_d.rsp.prdata = {16'h0000, s_q.capb};
        ecp_pkg::OFF_COUNT:  s_d.rsp.prdata = {16'h0000, s_q.cnt};
        ecp_pkg::OFF_STATUS: s_d.rsp.prdata = {31'h0000_0000, s_q.ovf};
        default:             s_d.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr_en) begin
      case (apb_req.paddr)
        ecp_pkg::OFF_MODE:   s_d.mode = ecp_pkg::ecp_mode_t'(apb_req.pwdata[1:0]);
        ecp_pkg::OFF_CCCTRL: s_d.cap_en = apb_req.pwdata[ecp_pkg::CAP_EN_BIT];
        ecp_pkg::OFF_PRESEL: s_d.presel = apb_req.pwdata[7:0] & 8'hf3;
        ecp_pkg::OFF_CMPA:   s_d.cmp = apb_req.pwdata[15:0];
        ecp_pkg::OFF_STATUS: s_d.ovf = s_q.ovf & ~apb_req.pwdata[ecp_pkg::OVF_BIT];
        default:             s_d.mode = s_q.mode;
      endcase
    end

    // counter side; hardware captures win over a software write to the compare
    if (!run) begin
      s_d.cnt = 16'h0000;
    end else if (s_q.mode == ecp_pkg::ECP_EVENT) begin
      if (cnt_tick) begin
        if (s_q.cnt == s_q.cmp) begin
          s_d.cnt = 16'h0000;
          s_d.irq_a = 1'b1;
          if (s_q.cmp == ecp_pkg::CNT_MAX) begin
            s_d.ovf = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
    end else begin
      if (cnt_tick) begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == ecp_pkg::CNT_MAX) begin
          s_d.ovf = 1'b1;
        end
      end
      if (sa_edge) begin
        s_d.capb = s_q.cnt;
        s_d.irq_b = 1'b1;
        if (s_q.mode == ecp_pkg::ECP_RESTART) begin
          s_d.cnt = 16'h0000;
        end
      end
      if (sb_edge) begin
        s_d.irq_a = 1'b1;
        if (s_q.cap_en) begin
          s_d.cmp = s_q.cnt;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q        <= '0;
      s_q.mode   <= ecp_pkg::ECP_STOP;
      s_q.cmp    <= ecp_pkg::CMP_RST;
      s_q.presel <= ecp_pkg::PRESEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp       = s_q.rsp;
  assign match_irq_a   = s_q.irq_a;
  assign capture_irq_b = s_q.irq_b;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_event_count_up: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && fa_edge && s_q.cnt != s_q.cmp
    |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("event edge did not advance the counter");
  chk_match_clear_irq: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && fa_edge && s_q.cnt == s_q.cmp
    |=> s_q.cnt == 16'h0000 && match_irq_a)
    else $error("compare match did not clear and interrupt");
  chk_ovf_only_ffff: assert property (
    $past(s_q.mode) == ecp_pkg::ECP_EVENT && $rose(s_q.ovf) |-> $past(s_q.cmp) == 16'hffff)
    else $error("overflow flag set with compare other than ffff");
  chk_prohibited_edge: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && edge_a == 2'b10 |=> s_q.cnt == $past(s_q.cnt))
    else $error("prohibited edge code changed the counter");
  chk_filter_twice: assert property (
    $rose(s_q.fa_lvl) |-> $past(event_input_a) && $past(event_input_a, 2))
    else $error("level accepted without two samples");
  chk_capture_b_copy: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && sa_edge |=> s_q.capb == $past(s_q.cnt) && capture_irq_b)
    else $error("capture_b did not take the counter");
  chk_capture_a_copy: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && sb_edge && s_q.cap_en
    |=> s_q.cmp == $past(s_q.cnt) && match_irq_a)
    else $error("compare_capture_a did not take the counter");
  chk_free_wrap_ovf: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && cnt_tick && s_q.cnt == 16'hffff
    |=> s_q.ovf && s_q.cnt == 16'h0000)
    else $error("free-running wrap did not set overflow");
  chk_restart_clear: assert property (
    s_q.mode == ecp_pkg::ECP_RESTART && sa_edge |=> s_q.cnt == 16'h0000 && capture_irq_b)
    else $error("restart edge did not clear the counter");
  chk_stop_quiet: assert property (
    s_q.mode == ecp_pkg::ECP_STOP |=> s_q.cnt == 16'h0000 && !match_irq_a && !capture_irq_b)
    else $error("stopped timer counted or interrupted");
  chk_div4_spacing: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && clk_sel == 2'b01 && cnt_tick
    |=> !cnt_tick [*3])
    else $error("divide-by-four count clock too fast");

  // bus answer: one wait state, ready and error for one cycle, data zero when idle
  chk_ready_one_wait: assert property (
    $rose(apb_req.psel && apb_req.penable) |=> apb_rsp.pready)
    else $error("access phase not answered after one wait state");
  chk_ready_single: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready stood longer than one cycle");
  chk_err_with_ready: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0000_0000)
    else $error("pslverr without pready or with read data");
  chk_idle_data_zero: assert property (
    !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000)
    else $error("read data shown outside the ready cycle");

  // counter must stay put whenever no valid tick reaches it, save the clears on entering stop and on a restart capture edge
  chk_event_hold: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && !fa_edge |=> s_q.cnt == $past(s_q.cnt))
    else $error("event counter moved without a valid edge");
  chk_rise_ignores_fall: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && edge_a == ecp_pkg::EDGE_RISE && s_q.fa_lvl
    |=> s_q.cnt == $past(s_q.cnt))
    else $error("rising-edge setting counted a falling edge");
  chk_fall_ignores_rise: assert property (
    s_q.mode == ecp_pkg::ECP_EVENT && edge_a == ecp_pkg::EDGE_FALL && !s_q.fa_lvl
    |=> s_q.cnt == $past(s_q.cnt))
    else $error("falling-edge setting counted a rising edge");
  chk_free_ovf_quiet: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && !s_q.ovf && !(cnt_tick && s_q.cnt == 16'hffff)
    |=> !s_q.ovf)
    else $error("overflow flag set without a counter wrap");
  chk_capb_hold: assert property (
    !(run && sa_edge) |=> s_q.capb == $past(s_q.capb))
    else $error("capture_b changed without a capture edge");
  chk_stop_ovf_hold: assert property (
    s_q.mode == ecp_pkg::ECP_STOP && !s_q.ovf |=> !s_q.ovf)
    else $error("stopped timer set the overflow flag");
  chk_div1_every: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && clk_sel == ecp_pkg::CLK_DIV1
    |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("undivided count clock missed a tick");
  chk_div256_spacing: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && clk_sel == ecp_pkg::CLK_DIV256 && cnt_tick
    |=> !cnt_tick [*8])
    else $error("divide-by-256 count clock too fast");
  chk_edge_clk_hold: assert property (
    s_q.mode == ecp_pkg::ECP_FREE && clk_sel == ecp_pkg::CLK_EDGE && !fa_edge
    |=> s_q.cnt == $past(s_q.cnt))
    else $error("pin count clock ticked without a valid edge");
  chk_restart_capture: assert property (
    s_q.mode == ecp_pkg::ECP_RESTART && sa_edge |=> s_q.capb == $past(s_q.cnt))
    else $error("restart edge did not capture the counter");
  chk_pin_b_irq_only: assert property (
    s_q.mode == ecp_pkg::ECP_RESTART && sb_edge && !s_q.cap_en && !wr_en
    |=> s_q.cmp == $past(s_q.cmp) && match_irq_a)
    else $error("pin b captured while capture was disabled");
endmodule : ecp_timer

/* File: sim/ecp_pins.sv */
// ecp_pins: far-side model that drives the event and capture pins
// assumes one caller at a time, entering its task just after a rising edge
module ecp_pins (
  // clock
  input  wire logic clk,
  // pins
  output      logic pin_a,
  output      logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // high for w cycles, then low for w: w >= 2 samples so the filter keeps it
  task automatic pulse(input bit sel_b, input int w);
    if (sel_b) pin_b <= 1'b1;
    else pin_a <= 1'b1;
    repeat (w) @(posedge clk);
    if (sel_b) pin_b <= 1'b0;
    else pin_a <= 1'b0;
    repeat (w) @(posedge clk);
  endtask : pulse
endmodule : ecp_pins

/* File: sim/ecp_timer_tb.sv */
// ecp_timer_tb: self-checking bench for the event counter / capture block
// assumes the APB slave answers within 20 cycles and the pin model above
module ecp_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk;
  logic                  rst;
  ecp_pkg::ecp_apb_req_t req;
  ecp_pkg::ecp_apb_rsp_t rsp;
  logic                  pin_a;
  logic                  pin_b;
  logic                  irq_a;
  logic                  irq_b;
  logic                  er;
  logic [31:0]           rd;
  logic [31:0]           c1;
  int                    mismatches;
  int                    n_compared;
  int                    n_a;
  int                    n_b;

  ecp_timer ecp_timer_inst (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .event_input_a(pin_a), .capture_input_b(pin_b), .match_irq_a(irq_a),
    .capture_irq_b(irq_b));
  ecp_pins ecp_pins_inst (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq_a === 1'b1) n_a++;
    if (irq_b === 1'b1) n_b++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // one transfer plus an idle cycle, so back-to-back calls never double-drive req
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      mismatches++;
      summarize();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic t_reset;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({rd[30:0], er}, 32'h1);
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'hffff_ffff);
    apb(1'b0, ecp_pkg::OFF_PRESEL, 32'h0);
    check(rd, 32'h0000_00f3);
  endtask : t_reset

  task automatic t_edges;
    logic [1:0] code [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [31:0] exp [4] = '{32'h1, 32'h1, 32'h2, 32'h0};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
      apb(1'b1, ecp_pkg::OFF_PRESEL, {26'h0, code[i], 4'h0});
      apb(1'b1, ecp_pkg::OFF_CMPA, 32'h00ff);
      apb(1'b1, ecp_pkg::OFF_MODE, 32'h1);
      ecp_pins_inst.pulse(1'b0, 4);
      apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
      check(rd, exp[i]);
    end
  endtask : t_edges

  task automatic t_match;
    int n0;
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    apb(1'b1, ecp_pkg::OFF_CCCTRL, 32'h0);
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'h10);
    apb(1'b1, ecp_pkg::OFF_CMPA, 32'h2);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h1);
    n0 = n_a;
    ecp_pins_inst.pulse(1'b0, 3);
    ecp_pins_inst.pulse(1'b0, 3);
    apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'h2);
    check(n_a - n0, 0);
    ecp_pins_inst.pulse(1'b0, 3);
    apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'h0);
    check(n_a - n0, 1);
    apb(1'b0, ecp_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h0);
  endtask : t_match

  // both edges on pin a: the capture spacing equals the pulse width in count ticks
  task automatic t_capture(input logic [1:0] sel, input int w, input logic [31:0] exp);
    int na;
    int nb;
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    apb(1'b1, ecp_pkg::OFF_CCCTRL, 32'h1);
    apb(1'b1, ecp_pkg::OFF_PRESEL, {24'h0, 6'h1c, sel});
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h2);
    nb = n_b;
    fork
      ecp_pins_inst.pulse(1'b0, w);
      begin
        repeat (w / 2) @(posedge clk);
        apb(1'b0, ecp_pkg::OFF_CAPB, 32'h0);
        c1 = rd;
      end
    join
    apb(1'b0, ecp_pkg::OFF_CAPB, 32'h0);
    check(rd - c1, exp);
    check(n_b - nb, 2);
    na = n_a;
    ecp_pins_inst.pulse(1'b1, 8);
    check(n_a - na, 1);
    apb(1'b0, ecp_pkg::OFF_CMPA, 32'h0);
    check(32'(rd[15:0] > c1[15:0]), 1);
  endtask : t_capture

  // restart: each valid edge on pin a captures then clears; the clear stands in
  // for one count, so a pulse of w ticks reads back as w - 1
  task automatic t_restart;
    int na;
    int nb;
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    apb(1'b1, ecp_pkg::OFF_CCCTRL, 32'h0);
    apb(1'b1, ecp_pkg::OFF_CMPA, 32'h1234);
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'h70);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h3);
    nb = n_b;
    ecp_pins_inst.pulse(1'b0, 12);
    apb(1'b0, ecp_pkg::OFF_CAPB, 32'h0);
    check(rd, 32'd11);
    check(n_b - nb, 2);
    na = n_a;
    ecp_pins_inst.pulse(1'b1, 4);
    check(n_a - na, 1);
    apb(1'b0, ecp_pkg::OFF_CMPA, 32'h0);
    check(rd, 32'h1234);
  endtask : t_restart

  // pin a edges as count clock, then divide-by-256
  task automatic t_clocks;
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'h13);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h2);
    ecp_pins_inst.pulse(1'b0, 4);
    ecp_pins_inst.pulse(1'b0, 4);
    apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'h02);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h2);
    repeat (1024) @(posedge clk);
    apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
    // about 1026 clocks pass: four or five ticks, whatever the prescaler phase
    check(32'(rd == 32'h4 || rd == 32'h5), 32'h1);
  endtask : t_clocks

  task automatic t_stop;
    int na;
    int nb;
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h0);
    na = n_a;
    nb = n_b;
    ecp_pins_inst.pulse(1'b0, 4);
    ecp_pins_inst.pulse(1'b1, 4);
    apb(1'b0, ecp_pkg::OFF_COUNT, 32'h0);
    check(rd, 32'h0);
    check(n_a - na + n_b - nb, 0);
  endtask : t_stop

  task automatic t_wrap;
    apb(1'b1, ecp_pkg::OFF_PRESEL, 32'h0);
    apb(1'b1, ecp_pkg::OFF_STATUS, 32'h1);
    apb(1'b1, ecp_pkg::OFF_MODE, 32'h2);
    repeat (66000) @(posedge clk);
    apb(1'b0, ecp_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, ecp_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, ecp_pkg::OFF_STATUS, 32'h0);
    check(rd, 32'h0);
  endtask : t_wrap

  initial begin
    req = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_edges();
    t_match();
    t_capture(2'b00, 20, 32'd20);
    t_capture(2'b01, 40, 32'd10);
    t_restart();
    t_clocks();
    t_stop();
    t_wrap();
    summarize();
  end
endmodule : ecp_timer_tb
